/* hdl/sspi_pkg.sv */
// How it works
// - chip select high means selected
// - control word latched at select fall
// - status loaded into shifter at select rise
// - deselected: clock, data ignored, output floats
// - data in sampled on clock rise
// - status bit zero first, next bit each rise
// - both words least significant bit first
// - exactly sixteen bits per transfer
// - bits 0-3 switch supplies, reset one
// - bit 4 prog supply, bit 5 level
// - bit 6 enables CAN receiver
// - bit 7 arms CAN wake-up
// - armed activity in low power wakes device
// - sleep input falling edge enters low power
// - thermal events latch status bits 4-7
// - reported thermal latches clear at select fall
// - status bits 0-3 live current limit
package sspi_pkg;

    // ----------------------------------------
    // word layout
    // ----------------------------------------
    localparam int WORD_BITS = 16;
    localparam int COUNT_W = 5;
    localparam logic [COUNT_W-1:0] COUNT_FULL = 5'h10;
    localparam logic [COUNT_W-1:0] COUNT_OVER = 5'h11;
    localparam int CTRL_BITS = 8;
    localparam int SUPPLY_COUNT = 4;

    // control field positions
    localparam int CTRL_SENSOR_ONE = 0;
    localparam int CTRL_SENSOR_TWO = 1;
    localparam int CTRL_SENSOR_THREE = 2;
    localparam int CTRL_SWITCHED_BATTERY = 3;
    localparam int CTRL_PROG_ENABLE = 4;
    localparam int CTRL_PROG_LEVEL = 5;
    localparam int CTRL_CAN_RX_ENABLE = 6;
    localparam int CTRL_CAN_WAKE_ARM = 7;
    localparam logic [CTRL_BITS-1:0] CTRL_RESET = 8'hFF;

    // status field positions
    localparam int STAT_CURRENT_LSB = 0;
    localparam int STAT_THERMAL_LSB = 4;
    localparam logic [7:0] STAT_UPPER_ZERO = 8'h00;
    localparam logic [SUPPLY_COUNT-1:0] THERMAL_RESET = 4'h0;

    // ----------------------------------------
    // host timing, in own units and cycles
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int CS_LEAD_NS = 125;
    localparam int CS_LEAD_CYC = (CS_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_MIN_PERIOD_NS = 200;
    localparam int SCLK_MIN_PERIOD_CYC =
        (SCLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // power mode machine
    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'h0,
        PWR_LOW = 2'h1,
        PWR_POWER_UP = 2'h3
    } sspi_pwr_e;

endpackage

/* hdl/sspi_stat_if.sv */
`timescale 1ns/1ps
// status capture and clear path between core and thermal latch bank
interface sspi_stat_if;
    logic capture;
    logic clear;
    logic [sspi_pkg::WORD_BITS-1:0] status_word;

    modport core (
        output capture,
        output clear,
        input status_word
    );
    modport latch (
        input capture,
        input clear,
        output status_word
    );
endinterface

/* hdl/sspi_thermal_latch.sv */
`timescale 1ns/1ps
module sspi_thermal_latch (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [sspi_pkg::SUPPLY_COUNT-1:0] i_thermal_limit,
    input wire logic [sspi_pkg::SUPPLY_COUNT-1:0] i_current_limit,
    sspi_stat_if.latch stat
);
    typedef struct packed {
        logic [sspi_pkg::SUPPLY_COUNT-1:0] thermal;
        logic [sspi_pkg::SUPPLY_COUNT-1:0] reported;
    } sspi_latch_s;

    sspi_latch_s state_ff;
    sspi_latch_s nxt_state;

    // ----------------------------------------
    // latch update
    // ----------------------------------------
    // only bits already reported are cleared; a new event always wins
    always_comb begin
        nxt_state = state_ff;
        if (stat.capture) begin
            nxt_state.reported = state_ff.thermal;
        end
        if (stat.clear) begin
            nxt_state.thermal = (state_ff.thermal & ~state_ff.reported) | i_thermal_limit;
            nxt_state.reported = sspi_pkg::THERMAL_RESET;
        end else begin
            nxt_state.thermal = state_ff.thermal | i_thermal_limit;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_ff <= '{thermal: sspi_pkg::THERMAL_RESET, reported: sspi_pkg::THERMAL_RESET};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------
    // status word, current flags are live
    // ----------------------------------------
    assign stat.status_word = {sspi_pkg::STAT_UPPER_ZERO, state_ff.thermal, i_current_limit};
endmodule

/* hdl/sspi_top.sv */
`timescale 1ns/1ps
module sspi_top (
    input wire logic i_clock,
    input wire logic i_srst,
    // serial pins
    input wire logic i_cs,
    input wire logic i_sclk,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe,
    // supply fault inputs
    input wire logic [sspi_pkg::SUPPLY_COUNT-1:0] i_thermal_limit,
    input wire logic [sspi_pkg::SUPPLY_COUNT-1:0] i_current_limit,
    // power mode inputs
    input wire logic i_sleep_n,
    input wire logic i_can_bus_activity,
    input wire logic i_power_up_done,
    // control outputs
    output logic o_sensor_supply_one_enable,
    output logic o_sensor_supply_two_enable,
    output logic o_sensor_supply_three_enable,
    output logic o_switched_battery_enable,
    output logic o_prog_supply_enable,
    output logic o_prog_supply_5v_select,
    output logic o_can_receiver_enable,
    output logic o_can_wake_arm,
    // power mode and frame error outputs
    output logic o_wake_indication,
    output logic o_low_power,
    output logic o_power_up_request,
    output logic o_frame_error
);

    // ----------------------------------------
    // state record
    // ----------------------------------------
    typedef struct packed {
        logic cs;
        logic sclk;
        logic sleep_n;
        logic [sspi_pkg::WORD_BITS-1:0] shift;
        logic [sspi_pkg::COUNT_W-1:0] count;
        logic [sspi_pkg::CTRL_BITS-1:0] ctrl;
        logic sdo;
        logic sdo_oe;
        sspi_pkg::sspi_pwr_e pwr;
        logic wake;
        logic pwr_req;
        logic frame_err;
    } sspi_core_s;

    sspi_core_s state_ff;
    sspi_core_s nxt_state;

    sspi_stat_if stat ();

    // ----------------------------------------
    // edge helpers
    // ----------------------------------------
    // pins are synchronous, so the previous sample is the only history needed
    function automatic logic rose(input logic cur, input logic prev);
        rose = cur & ~prev;
    endfunction

    function automatic logic fell(input logic cur, input logic prev);
        fell = ~cur & prev;
    endfunction

    // ----------------------------------------
    // edge events
    // ----------------------------------------
    logic cs_rise;
    logic cs_fall;
    logic sclk_rise;
    logic sleep_fall;
    logic sleep_rise;

    // clock edges count only while select is high on both samples
    assign cs_rise = rose(i_cs, state_ff.cs);
    assign cs_fall = fell(i_cs, state_ff.cs);
    assign sclk_rise = rose(i_sclk, state_ff.sclk) & i_cs & state_ff.cs;
    assign sleep_fall = fell(i_sleep_n, state_ff.sleep_n);
    assign sleep_rise = rose(i_sleep_n, state_ff.sleep_n);

    // status snapshot at select rise, latch clear at select fall
    assign stat.capture = cs_rise;
    assign stat.clear = cs_fall;

    // ----------------------------------------
    // thermal latch bank
    // ----------------------------------------
    sspi_thermal_latch u_latch (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_thermal_limit(i_thermal_limit),
        .i_current_limit(i_current_limit),
        .stat(stat.latch)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.cs = i_cs;
        nxt_state.sclk = i_sclk;
        nxt_state.sleep_n = i_sleep_n;

        // serial transfer: one shifter serves both directions
        if (cs_rise) begin
            nxt_state.shift = stat.status_word;
            nxt_state.count = '0;
        end else if (sclk_rise) begin
            // new bit enters at the top, oldest leaves at bit zero
            nxt_state.shift = {i_sdi, state_ff.shift[sspi_pkg::WORD_BITS-1:1]};
            if (state_ff.count != sspi_pkg::COUNT_OVER) begin
                nxt_state.count = state_ff.count + 5'h01;
            end
        end

        // data out follows bit zero of the shifter while selected
        nxt_state.sdo = nxt_state.shift[0];
        nxt_state.sdo_oe = i_cs;

        // a short or long word is dropped rather than half applied
        if (cs_fall) begin
            if (state_ff.count == sspi_pkg::COUNT_FULL) begin
                nxt_state.ctrl = state_ff.shift[sspi_pkg::CTRL_BITS-1:0];
                nxt_state.frame_err = 1'b0;
            end else begin
                nxt_state.frame_err = 1'b1;
            end
        end

        // power mode machine
        case (state_ff.pwr)
            sspi_pkg::PWR_ACTIVE: begin
                if (sleep_fall) begin
                    nxt_state.pwr = sspi_pkg::PWR_LOW;
                    nxt_state.wake = 1'b0;
                end
            end
            sspi_pkg::PWR_LOW: begin
                if (state_ff.ctrl[sspi_pkg::CTRL_CAN_WAKE_ARM] && i_can_bus_activity) begin
                    nxt_state.pwr = sspi_pkg::PWR_POWER_UP;
                    nxt_state.pwr_req = 1'b1;
                    nxt_state.wake = 1'b1;
                end else if (sleep_rise) begin
                    nxt_state.pwr = sspi_pkg::PWR_POWER_UP;
                    nxt_state.pwr_req = 1'b1;
                end
            end
            sspi_pkg::PWR_POWER_UP: begin
                // a sleep request during power up wins over completion
                if (sleep_fall) begin
                    nxt_state.pwr = sspi_pkg::PWR_LOW;
                    nxt_state.pwr_req = 1'b0;
                    nxt_state.wake = 1'b0;
                end else if (i_power_up_done) begin
                    nxt_state.pwr = sspi_pkg::PWR_ACTIVE;
                    nxt_state.pwr_req = 1'b0;
                end
            end
            default: begin
                nxt_state.pwr = sspi_pkg::PWR_ACTIVE;
                nxt_state.pwr_req = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // sleep sample resets low so a low pin at release is not a falling edge
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_ff.cs <= 1'b0;
            state_ff.sclk <= 1'b0;
            state_ff.sleep_n <= 1'b0;
            state_ff.shift <= '0;
            state_ff.count <= '0;
            state_ff.ctrl <= sspi_pkg::CTRL_RESET;
            state_ff.sdo <= 1'b0;
            state_ff.sdo_oe <= 1'b0;
            state_ff.pwr <= sspi_pkg::PWR_ACTIVE;
            state_ff.wake <= 1'b0;
            state_ff.pwr_req <= 1'b0;
            state_ff.frame_err <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------
    // outputs, all from the state register
    // ----------------------------------------
    assign o_sdo = state_ff.sdo;
    assign o_sdo_oe = state_ff.sdo_oe;

    // supply switches
    assign o_sensor_supply_one_enable = state_ff.ctrl[sspi_pkg::CTRL_SENSOR_ONE];
    assign o_sensor_supply_two_enable = state_ff.ctrl[sspi_pkg::CTRL_SENSOR_TWO];
    assign o_sensor_supply_three_enable = state_ff.ctrl[sspi_pkg::CTRL_SENSOR_THREE];
    assign o_switched_battery_enable = state_ff.ctrl[sspi_pkg::CTRL_SWITCHED_BATTERY];
    assign o_prog_supply_enable = state_ff.ctrl[sspi_pkg::CTRL_PROG_ENABLE];
    assign o_prog_supply_5v_select = state_ff.ctrl[sspi_pkg::CTRL_PROG_LEVEL];

    // CAN side; upper command bits pass through the shifter but have no control flop
    assign o_can_receiver_enable = state_ff.ctrl[sspi_pkg::CTRL_CAN_RX_ENABLE];
    assign o_can_wake_arm = state_ff.ctrl[sspi_pkg::CTRL_CAN_WAKE_ARM];

    // power mode and frame error
    assign o_wake_indication = state_ff.wake;
    assign o_low_power = (state_ff.pwr == sspi_pkg::PWR_LOW);
    assign o_power_up_request = state_ff.pwr_req;
    assign o_frame_error = state_ff.frame_err;
endmodule

/* sim/sspi_checker.sv */
`timescale 1ns/1ps
module sspi_checker (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_cs,
    input wire logic i_sclk,
    input wire logic i_sleep_n,
    input wire logic i_can_bus_activity,
    input wire logic [sspi_pkg::SUPPLY_COUNT-1:0] i_current_limit,
    input wire logic o_sdo,
    input wire logic o_sdo_oe,
    input wire logic o_can_wake_arm,
    input wire logic o_frame_error,
    input wire logic o_wake_indication,
    input wire logic o_low_power,
    input wire logic o_power_up_request
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);

    // ----
    // pin history; select, clock and sleep cleared as the block clears its own, current bit not cleared
    // ----
    logic cs_ff, sclk_ff, sleep_ff, cur0_ff;
    always_ff @(posedge i_clock) begin
        cs_ff <= i_srst ? 1'b0 : i_cs;
        sclk_ff <= i_srst ? 1'b0 : i_sclk;
        sleep_ff <= i_srst ? 1'b0 : i_sleep_n;
        cur0_ff <= i_current_limit[0];
    end

    // ----
    // serial link
    // ----
    AST_OE_TRACKS_SELECT: assert property (!$past(i_srst) |-> o_sdo_oe == $past(i_cs))
        else $error("data output enable does not follow select");
    AST_BIT0_AT_SELECT: assert property (i_cs && !cs_ff |=> o_sdo == cur0_ff)
        else $error("first status bit not shown after select rise");
    AST_SDO_HOLDS: assert property (i_cs && cs_ff && !(i_sclk && !sclk_ff) |=> $stable(o_sdo))
        else $error("data output moved without a clock rise");
    AST_CTRL_AT_FALL: assert property (!(cs_ff && !i_cs) |=> $stable(o_can_wake_arm))
        else $error("control changed away from select fall");
    AST_FERR_AT_FALL: assert property (!(cs_ff && !i_cs) |=> $stable(o_frame_error))
        else $error("frame error changed away from select fall");
    AST_CTRL_WHOLE_WORD: assert property (!$stable(o_can_wake_arm) |-> !o_frame_error)
        else $error("control taken from a short word");

    // ----
    // power mode
    // ----
    AST_WAKE_CAUSE: assert property ($rose(o_wake_indication) |->
        $past(o_can_wake_arm) && $past(i_can_bus_activity) && o_power_up_request)
        else $error("wake without armed activity");
    AST_SLEEP_FALL: assert property (sleep_ff && !i_sleep_n |=> o_low_power && !o_wake_indication)
        else $error("sleep fall did not enter low power");

    COV_SELECT: cover property (i_cs && !cs_ff);
    COV_WAKE: cover property ($rose(o_wake_indication));
    COV_FERR: cover property ($rose(o_frame_error));
endmodule

bind sspi_top sspi_checker u_chk (
    .i_clock, .i_srst, .i_cs, .i_sclk, .i_sleep_n, .i_can_bus_activity, .i_current_limit,
    .o_sdo, .o_sdo_oe, .o_can_wake_arm, .o_frame_error, .o_wake_indication, .o_low_power,
    .o_power_up_request
);

/* sim/sspi_host_model.sv */
`timescale 1ns/1ps
// serial master; clock idles low so select never moves mid-pulse
module sspi_host_model (
    input wire logic i_clock,
    input wire logic i_sdo,
    output logic o_cs,
    output logic o_sclk,
    output logic o_sdi
);
    initial begin
        o_cs = 1'b0;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end

    // ----
    // one frame of n bits, lsb first both ways
    // ----
    task automatic xfer(input logic [15:0] cmd, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge i_clock);
        o_cs <= 1'b1;
        o_sdi <= cmd[0];
        repeat (14) @(posedge i_clock);
        for (int i = 0; i < n; i++) begin
            rx[i] = i_sdo;
            o_sclk <= 1'b1;
            repeat (10) @(posedge i_clock);
            o_sclk <= 1'b0;
            o_sdi <= cmd[(i + 1) % 16];
            repeat (10) @(posedge i_clock);
        end
        o_cs <= 1'b0;
        o_sdi <= ~o_sdi; // released line must not keep the last bit
        repeat (3) @(posedge i_clock);
    endtask
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
    logic i_clock, i_srst, i_cs, i_sclk, i_sdi, i_sleep_n, i_can_bus_activity;
    logic i_power_up_done, o_sdo, o_sdo_oe, o_frame_error, o_can_wake_arm;
    logic [3:0] i_thermal_limit, i_current_limit;
    logic o_sensor_supply_one_enable, o_sensor_supply_two_enable;
    logic o_sensor_supply_three_enable, o_switched_battery_enable, o_prog_supply_enable;
    logic o_prog_supply_5v_select, o_can_receiver_enable;
    logic o_wake_indication, o_low_power, o_power_up_request;
    logic [15:0] rx;
    int fail_count = 0;
    int checks_done = 0;
    // no pull on the data line, so an idle output floats
    wire sdo_w = o_sdo_oe ? o_sdo : 1'bz;
    wire [15:0] ctrl = {8'h00, o_can_wake_arm, o_can_receiver_enable, o_prog_supply_5v_select,
        o_prog_supply_enable, o_switched_battery_enable, o_sensor_supply_three_enable,
        o_sensor_supply_two_enable, o_sensor_supply_one_enable};
    wire [15:0] mode = {13'h0000, o_low_power, o_power_up_request, o_wake_indication};
    wire [15:0] ferr = {15'h0000, o_frame_error};

    sspi_top uut (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_cs(i_cs),
        .i_sclk(i_sclk),
        .i_sdi(i_sdi),
        .o_sdo(o_sdo),
        .o_sdo_oe(o_sdo_oe),
        .i_thermal_limit(i_thermal_limit),
        .i_current_limit(i_current_limit),
        .i_sleep_n(i_sleep_n),
        .i_can_bus_activity(i_can_bus_activity),
        .i_power_up_done(i_power_up_done),
        .o_sensor_supply_one_enable(o_sensor_supply_one_enable),
        .o_sensor_supply_two_enable(o_sensor_supply_two_enable),
        .o_sensor_supply_three_enable(o_sensor_supply_three_enable),
        .o_switched_battery_enable(o_switched_battery_enable),
        .o_prog_supply_enable(o_prog_supply_enable),
        .o_prog_supply_5v_select(o_prog_supply_5v_select),
        .o_can_receiver_enable(o_can_receiver_enable),
        .o_can_wake_arm(o_can_wake_arm),
        .o_wake_indication(o_wake_indication),
        .o_low_power(o_low_power),
        .o_power_up_request(o_power_up_request),
        .o_frame_error(o_frame_error)
    );
    sspi_host_model host (.i_clock, .i_sdo(sdo_w), .o_cs(i_cs), .o_sclk(i_sclk), .o_sdi(i_sdi));

    always #5 i_clock = ~i_clock;

    // ----
    // judging and closing
    // ----
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_ctrl();
        logic [15:0] w [3] = '{16'hFF5A, 16'h00A5, 16'h3C80};
        foreach (w[i]) begin
            host.xfer(w[i], 16, rx);
            chk("ctrl", ctrl, {8'h00, w[i][7:0]});
            chk("ferr", ferr, 16'h0000);
        end
    endtask

    task automatic t_status();
        i_current_limit <= 4'h5;
        i_thermal_limit <= 4'hA;
        @(posedge i_clock);
        i_thermal_limit <= 4'h0;
        host.xfer(16'h0080, 16, rx);
        chk("status", rx, 16'h00A5);
        i_current_limit <= 4'h2;
        host.xfer(16'h0080, 16, rx);
        chk("status", rx, 16'h0002);
        // an event inside a frame was never reported, so it must survive the fall
        fork
            host.xfer(16'h0080, 16, rx);
            begin
                repeat (40) @(posedge i_clock);
                i_thermal_limit <= 4'h1;
                @(posedge i_clock);
                i_thermal_limit <= 4'h0;
            end
        join
        chk("status", rx, 16'h0002);
        host.xfer(16'h0080, 16, rx);
        chk("status", rx, 16'h0012);
    endtask

    task automatic t_short();
        host.xfer(16'h0000, 8, rx);
        chk("ferr", ferr, 16'h0001);
        chk("ctrl", ctrl, 16'h0080);
        host.xfer(16'h0080, 16, rx);
        chk("ferr", ferr, 16'h0000);
    endtask

    task automatic t_power();
        i_sleep_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        chk("mode", mode, 16'h0004);
        i_can_bus_activity <= 1'b1;
        repeat (2) @(posedge i_clock);
        chk("mode", mode, 16'h0003);
        i_can_bus_activity <= 1'b0;
        i_power_up_done <= 1'b1;
        repeat (2) @(posedge i_clock);
        chk("mode", mode, 16'h0001);
        i_power_up_done <= 1'b0;
        i_sleep_n <= 1'b1;
        host.xfer(16'h0000, 16, rx);
        i_sleep_n <= 1'b0;
        i_can_bus_activity <= 1'b1;
        repeat (3) @(posedge i_clock);
        chk("mode", mode, 16'h0004);
        // leave low power by the pin, then sleep again before power up ends
        i_can_bus_activity <= 1'b0;
        i_sleep_n <= 1'b1;
        repeat (2) @(posedge i_clock);
        chk("mode", mode, 16'h0002);
        i_sleep_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        chk("mode", mode, 16'h0004);
    endtask

    initial begin
        i_clock = 1'b0;
        i_srst = 1'b1;
        i_sleep_n = 1'b1;
        i_can_bus_activity = 1'b0;
        i_power_up_done = 1'b0;
        i_thermal_limit = 4'h0;
        i_current_limit = 4'h0;
        repeat (2) @(posedge i_clock);
        i_srst <= 1'b0;
        @(posedge i_clock);
        chk("reset", {ctrl[7:0], 3'h0, o_sdo_oe, ferr[0], mode[2:0]}, 16'hFF00);
        t_ctrl();
        t_status();
        t_short();
        t_power();
        report_and_stop();
    end

    // the run needs some 3200 cycles; six times that is a hang
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
endmodule
